// ### hw/jpd_prog_regs.sv
// Programming data registers selected by the test access port instruction
`timescale 1ns/1ns
`default_nettype none
module jpd_prog_regs (
    // Clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_ce,
    // Serial pins
    input  wire logic        i_tck,
    input  wire logic        i_tdi,
    output logic             o_tdo,
    output logic             o_tdo_oe,
    // TAP controller status, test clock domain
    input  wire logic [3:0]  i_ir,
    input  wire logic        i_shift_dr,
    input  wire logic        i_capture_dr,
    input  wire logic        i_update_dr,
    input  wire logic        i_run_idle,
    // Device control
    output logic             o_dev_reset,
    output logic             o_prog_mode,
    // Flash command port
    output logic [14:0]      o_cmd,
    output logic             o_cmd_apply,
    output logic             o_cmd_exec,
    input  wire logic [14:0] i_cmd_result,
    // Page buffer write
    output logic             o_pb_wr,
    output logic [6:0]       o_pb_addr,
    output logic [7:0]       o_pb_wdata,
    // Page buffer read
    output logic             o_pr_req,
    output logic [6:0]       o_pr_addr,
    input  wire logic [7:0]  i_pr_rdata
);
    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    logic [jpd_pkg::SYN_W-1:0] syn;
    logic                      tck_s, tdi_s, shift_s, capture_s, update_s, idle_s;
    logic [3:0]                ir_s;

    jpd_sync #(.W(jpd_pkg::SYN_W)) u_sync (
        .i_clk   (i_clk),
        .i_arst_n(i_arst_n),
        .i_ce    (i_ce),
        .i_async ({i_ir, i_run_idle, i_update_dr, i_capture_dr, i_shift_dr, i_tdi, i_tck}),
        .o_sync  (syn)
    );

    assign tck_s     = syn[jpd_pkg::SYN_TCK];
    assign tdi_s     = syn[jpd_pkg::SYN_TDI];
    assign shift_s   = syn[jpd_pkg::SYN_SHIFT];
    assign capture_s = syn[jpd_pkg::SYN_CAPTURE];
    assign update_s  = syn[jpd_pkg::SYN_UPDATE];
    assign idle_s    = syn[jpd_pkg::SYN_IDLE];
    assign ir_s      = syn[jpd_pkg::SYN_IR_LO +: jpd_pkg::IR_W];

    // ----------------------------------------
    // Byte shifter
    // ----------------------------------------
    jpd_shift_if sh ();

    jpd_byte_shifter u_shifter (
        .i_clk   (i_clk),
        .i_arst_n(i_arst_n),
        .i_ce    (i_ce),
        .bus     (sh.sh)
    );

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic                      tck_prev_q, tck_prev_d;
    logic                      tck_rise, tck_fall;
    logic                      rst_q, rst_d;
    logic [jpd_pkg::PE_W-1:0]  pe_q, pe_d;
    logic                      prog_q, prog_d;
    logic [jpd_pkg::CMD_W-1:0] cmd_q, cmd_d;
    logic [jpd_pkg::CMD_W-1:0] cmd_out_q, cmd_out_d;
    logic                      apply_q, apply_d;
    logic                      exec_q, exec_d;
    logic                      idle_prev_q, idle_prev_d;
    logic [2:0]                bit_q, bit_d;
    logic [6:0]                addr_q, addr_d;
    logic                      wr_pend_q, wr_pend_d;
    logic                      pb_wr_q, pb_wr_d;
    logic [6:0]                pb_addr_q, pb_addr_d;
    logic [7:0]                pb_data_q, pb_data_d;
    logic                      pr_req_q, pr_req_d;
    logic [6:0]                pr_addr_q, pr_addr_d;
    logic                      tdo_q, tdo_d;
    logic                      tdo_oe_q, tdo_oe_d;
    logic                      sel_lsb;
    logic                      known_ir;

    assign tck_rise = tck_s & ~tck_prev_q;
    assign tck_fall = ~tck_s & tck_prev_q;

    // Bit presented on the serial output for the selected chain
    always_comb begin
        sel_lsb  = 1'b0;
        known_ir = 1'b1;
        unique case (ir_s)
            jpd_pkg::INSTR_DEV_RESET: sel_lsb = rst_q;
            jpd_pkg::INSTR_PROG_EN:   sel_lsb = pe_q[0];
            jpd_pkg::INSTR_PROG_CMD:  sel_lsb = cmd_q[0];
            jpd_pkg::INSTR_PAGE_LOAD: sel_lsb = sh.data[0];
            jpd_pkg::INSTR_PAGE_READ: sel_lsb = sh.data[0];
            default:                  known_ir = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        tck_prev_d   = tck_s;
        rst_d        = rst_q;
        pe_d         = pe_q;
        prog_d       = prog_q;
        cmd_d        = cmd_q;
        cmd_out_d    = cmd_out_q;
        apply_d      = 1'b0;
        exec_d       = 1'b0;
        idle_prev_d  = idle_prev_q;
        bit_d        = bit_q;
        addr_d       = addr_q;
        wr_pend_d    = wr_pend_q;
        pb_wr_d      = 1'b0;
        pb_addr_d    = pb_addr_q;
        pb_data_d    = pb_data_q;
        pr_req_d     = 1'b0;
        pr_addr_d    = pr_addr_q;
        tdo_d        = tdo_q;
        tdo_oe_d     = tdo_oe_q;
        sh.shift     = 1'b0;
        sh.load      = 1'b0;
        sh.sin       = 1'b0;
        sh.load_data = i_pr_rdata;

        // Other states and codes fall through and hold everything but idle_prev_q
        if (tck_rise) begin
            idle_prev_d = idle_s;
            unique case (ir_s)
                jpd_pkg::INSTR_DEV_RESET: begin
                    if (shift_s) begin
                        rst_d = tdi_s;
                    end
                end
                jpd_pkg::INSTR_PROG_EN: begin
                    if (shift_s) begin
                        pe_d = {tdi_s, pe_q[jpd_pkg::PE_W-1:1]};
                    end else if (update_s) begin
                        prog_d = (pe_q == jpd_pkg::PE_SIGNATURE);
                    end
                end
                jpd_pkg::INSTR_PROG_CMD: begin
                    if (capture_s) begin
                        cmd_d = i_cmd_result;
                    end else if (shift_s) begin
                        cmd_d = {tdi_s, cmd_q[jpd_pkg::CMD_W-1:1]};
                    end else if (update_s) begin
                        cmd_out_d = cmd_q;
                        apply_d   = prog_q;
                    end else if (idle_s && !idle_prev_q) begin
                        exec_d = prog_q;
                    end
                end
                jpd_pkg::INSTR_PAGE_LOAD: begin
                    if (capture_s) begin
                        bit_d  = '0;
                        addr_d = '0;
                    end else if (shift_s) begin
                        sh.shift = 1'b1;
                        sh.sin   = tdi_s;
                        bit_d    = bit_q + jpd_pkg::BIT_ONE;
                        if (bit_q == jpd_pkg::BIT_LAST) begin
                            wr_pend_d = prog_q;
                        end
                    end
                end
                jpd_pkg::INSTR_PAGE_READ: begin
                    // Counters restart here; the shifter itself is left alone
                    if (capture_s) begin
                        bit_d     = '0;
                        addr_d    = '0;
                        pr_addr_d = '0;
                        pr_req_d  = prog_q;
                    end else if (shift_s) begin
                        bit_d = bit_q + jpd_pkg::BIT_ONE;
                        if (bit_q == jpd_pkg::BIT_LAST) begin
                            // First byte out is filler while byte 0 is fetched
                            sh.load   = prog_q;
                            sh.shift  = ~prog_q;
                            addr_d    = addr_q + jpd_pkg::ADDR_ONE;
                            pr_addr_d = addr_q + jpd_pkg::ADDR_ONE;
                            pr_req_d  = prog_q;
                        end else begin
                            sh.shift = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Byte completed on the previous edge goes to the buffer
        if (wr_pend_q) begin
            wr_pend_d = 1'b0;
            pb_wr_d   = 1'b1;
            pb_data_d = sh.data;
            pb_addr_d = addr_q;
            addr_d    = addr_q + jpd_pkg::ADDR_ONE;
        end

        if (tck_fall) begin
            tdo_d    = sel_lsb;
            tdo_oe_d = shift_s & known_ir;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            tck_prev_q  <= 1'b0;
            rst_q       <= 1'b0;
            pe_q        <= jpd_pkg::PE_RESET;
            prog_q      <= 1'b0;
            cmd_q       <= jpd_pkg::CMD_RESET;
            cmd_out_q   <= jpd_pkg::CMD_RESET;
            apply_q     <= 1'b0;
            exec_q      <= 1'b0;
            idle_prev_q <= 1'b0;
            bit_q       <= '0;
            addr_q      <= '0;
            wr_pend_q   <= 1'b0;
            pb_wr_q     <= 1'b0;
            pb_addr_q   <= '0;
            pb_data_q   <= jpd_pkg::BYTE_RESET;
            pr_req_q    <= 1'b0;
            pr_addr_q   <= '0;
            tdo_q       <= 1'b0;
            tdo_oe_q    <= 1'b0;
        end else if (i_ce) begin
            tck_prev_q  <= tck_prev_d;
            rst_q       <= rst_d;
            pe_q        <= pe_d;
            prog_q      <= prog_d;
            cmd_q       <= cmd_d;
            cmd_out_q   <= cmd_out_d;
            apply_q     <= apply_d;
            exec_q      <= exec_d;
            idle_prev_q <= idle_prev_d;
            bit_q       <= bit_d;
            addr_q      <= addr_d;
            wr_pend_q   <= wr_pend_d;
            pb_wr_q     <= pb_wr_d;
            pb_addr_q   <= pb_addr_d;
            pb_data_q   <= pb_data_d;
            pr_req_q    <= pr_req_d;
            pr_addr_q   <= pr_addr_d;
            tdo_q       <= tdo_d;
            tdo_oe_q    <= tdo_oe_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_dev_reset = rst_q;
    assign o_prog_mode = prog_q;
    assign o_cmd       = cmd_out_q;
    assign o_cmd_apply = apply_q;
    assign o_cmd_exec  = exec_q;
    assign o_pb_wr     = pb_wr_q;
    assign o_pb_addr   = pb_addr_q;
    assign o_pb_wdata  = pb_data_q;
    assign o_pr_req    = pr_req_q;
    assign o_pr_addr   = pr_addr_q;
    assign o_tdo       = tdo_q;
    assign o_tdo_oe    = tdo_oe_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    logic ev;
    assign ev = i_ce & tck_rise;

    sequence s_idle_entry;
        ev && ir_s == jpd_pkg::INSTR_PROG_CMD && idle_s && !idle_prev_q && !capture_s
            && !shift_s && !update_s && prog_q;
    endsequence

    sequence s_load_byte_done;
        ev && ir_s == jpd_pkg::INSTR_PAGE_LOAD && shift_s && !capture_s
            && bit_q == jpd_pkg::BIT_LAST && prog_q;
    endsequence

    AST_RESET_FOLLOWS_CHAIN: assert property (
        ev && ir_s == jpd_pkg::INSTR_DEV_RESET && shift_s |=> o_dev_reset == $past(tdi_s)
    ) else $error("reset output does not follow reset chain");

    AST_RESET_HOLDS: assert property (
        !(ev && ir_s == jpd_pkg::INSTR_DEV_RESET && shift_s) |=> $stable(o_dev_reset)
    ) else $error("reset chain changed outside shift");

    AST_PE_ENTER: assert property (
        ev && ir_s == jpd_pkg::INSTR_PROG_EN && update_s && !shift_s
            && pe_q == jpd_pkg::PE_SIGNATURE |=> o_prog_mode
    ) else $error("valid signature did not enable programming");

    AST_PE_REJECT: assert property (
        ev && ir_s == jpd_pkg::INSTR_PROG_EN && update_s && !shift_s
            && pe_q != jpd_pkg::PE_SIGNATURE |=> !o_prog_mode
    ) else $error("wrong signature enabled programming");

    AST_PE_SHIFT_LSB: assert property (
        ev && ir_s == jpd_pkg::INSTR_PROG_EN && shift_s
            |=> pe_q == {$past(tdi_s), $past(pe_q[jpd_pkg::PE_W-1:1])}
    ) else $error("enable register did not shift lsb first");

    AST_CMD_CAPTURE: assert property (
        ev && ir_s == jpd_pkg::INSTR_PROG_CMD && capture_s |=> cmd_q == $past(i_cmd_result)
    ) else $error("command result not captured");

    AST_CMD_APPLY: assert property (
        ev && ir_s == jpd_pkg::INSTR_PROG_CMD && update_s && !capture_s && !shift_s && prog_q
            |=> o_cmd_apply && o_cmd == $past(cmd_q) ##1 !o_cmd_apply
    ) else $error("command not applied for exactly one cycle");

    AST_EXEC_ONCE: assert property (
        s_idle_entry |=> o_cmd_exec ##1 !o_cmd_exec [*4]
    ) else $error("execute clock not a single pulse");

    AST_PL_WRITE: assert property (
        s_load_byte_done ##1 i_ce |=> o_pb_wr && o_pb_wdata == $past(sh.data)
    ) else $error("completed byte not written to page buffer");

    AST_PR_NO_TDI: assert property (
        ev && ir_s == jpd_pkg::INSTR_PAGE_READ && shift_s && bit_q != jpd_pkg::BIT_LAST
            |=> sh.data[7] == 1'b0
    ) else $error("page read chain took serial input");
endmodule : jpd_prog_regs
`default_nettype wire

// ### shared/jpd_pkg.sv
// Constants for the programming data registers behind the test access port
`default_nettype none
package jpd_pkg;
    // ----------------------------------------
    // Instruction codes
    // ----------------------------------------
    localparam int          IR_W             = 4;
    localparam logic [3:0]  INSTR_DEV_RESET  = 4'hc;
    localparam logic [3:0]  INSTR_PROG_EN    = 4'h4;
    localparam logic [3:0]  INSTR_PROG_CMD   = 4'h5;
    localparam logic [3:0]  INSTR_PAGE_LOAD  = 4'h6;
    localparam logic [3:0]  INSTR_PAGE_READ  = 4'h7;
    // ----------------------------------------
    // Register widths and values
    // ----------------------------------------
    localparam int          PE_W             = 16;
    localparam int          CMD_W            = 15;
    localparam int          BYTE_W           = 8;
    localparam int          PAGE_BITS        = 1024;
    localparam int          READ_BITS        = 1032;
    localparam int          PAGE_ADDR_W      = 7;
    localparam logic [15:0] PE_SIGNATURE     = 16'ha370;
    localparam logic [15:0] PE_RESET         = 16'h0000;
    localparam logic [14:0] CMD_RESET        = 15'h0000;
    localparam logic [7:0]  BYTE_RESET       = 8'h00;
    localparam logic [2:0]  BIT_LAST         = 3'h7;
    localparam logic [2:0]  BIT_ONE          = 3'h1;
    localparam logic [6:0]  ADDR_ONE         = 7'h01;
    // ----------------------------------------
    // Synchroniser bit positions
    // ----------------------------------------
    localparam int          SYN_W            = 10;
    localparam int          SYN_TCK          = 0;
    localparam int          SYN_TDI          = 1;
    localparam int          SYN_SHIFT        = 2;
    localparam int          SYN_CAPTURE      = 3;
    localparam int          SYN_UPDATE       = 4;
    localparam int          SYN_IDLE         = 5;
    localparam int          SYN_IR_LO        = 6;
endpackage : jpd_pkg
`default_nettype wire

// ### shared/jpd_shift_if.sv
// Control and data of the internal byte shifter
`timescale 1ns/1ns
`default_nettype none
interface jpd_shift_if;
    logic       shift;
    logic       load;
    logic       sin;
    logic [7:0] load_data;
    logic [7:0] data;
    modport ctl (output shift, output load, output sin, output load_data, input data);
    modport sh  (input shift, input load, input sin, input load_data, output data);
endinterface : jpd_shift_if
`default_nettype wire

// ### hw/jpd_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module jpd_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_arst_n,
    input  wire logic         i_ce,
    // Data
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] s1_q, s2_q, s3_q, st_q;
    logic [W-1:0] st_d;

    // Change accepted only once two late stages agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            st_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : st_q[i];
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            st_q <= '0;
        end else if (i_ce) begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            st_q <= st_d;
        end
    end

    assign o_sync = st_q;
endmodule : jpd_sync
`default_nettype wire

// ### hw/jpd_byte_shifter.sv
// Eight-bit shifter behind the virtual page chains
`timescale 1ns/1ns
`default_nettype none
module jpd_byte_shifter (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    input  wire logic i_ce,
    // Shifter control
    jpd_shift_if.sh   bus
);
    logic [jpd_pkg::BYTE_W-1:0] data_q, data_d;

    always_comb begin
        data_d = data_q;
        if (bus.load) begin
            data_d = bus.load_data;
        end else if (bus.shift) begin
            data_d = {bus.sin, data_q[jpd_pkg::BYTE_W-1:1]};
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            data_q <= jpd_pkg::BYTE_RESET;
        end else if (i_ce) begin
            data_q <= data_d;
        end
    end

    assign bus.data = data_q;
endmodule : jpd_byte_shifter
`default_nettype wire

// ### sim/jpd_host_model.sv
// Test access port host that drives the serial pins and TAP state flags
`timescale 1ns/1ns
`default_nettype none
module jpd_host_model (
    // Serial pins
    output logic       o_tck,
    output logic       o_tdi,
    input  wire logic  i_tdo,
    // TAP state
    output logic [3:0] o_ir,
    output logic       o_shift_dr,
    output logic       o_capture_dr,
    output logic       o_update_dr,
    output logic       o_run_idle
);
    // ----------------------------------------
    // Pin state
    // ----------------------------------------
    // Test clock stands low between frames
    initial begin
        o_tck        = 1'b0;
        o_tdi        = 1'b0;
        o_ir         = 4'h0;
        o_shift_dr   = 1'b0;
        o_capture_dr = 1'b0;
        o_update_dr  = 1'b0;
        o_run_idle   = 1'b0;
    end
    // ----------------------------------------
    // Frame tasks
    // ----------------------------------------
    // Flags change only while tck is low
    task automatic tck_pulse();
        #160;
        o_tck = 1'b1;
        #160;
        o_tck = 1'b0;
    endtask : tck_pulse
    // Single device in chain, so page instructions are allowed
    task automatic set_ir(input logic [3:0] code);
        o_ir = code;
        tck_pulse();
    endtask : set_ir
    // Least significant bit first, out bit taken just before the falling edge
    task automatic dr_scan(input logic [31:0] din, input int n, input bit upd,
                           output logic [31:0] dout);
        dout         = '0;
        o_capture_dr = 1'b1;
        tck_pulse();
        o_capture_dr = 1'b0;
        o_shift_dr   = 1'b1;
        for (int i = 0; i < n; i++) begin
            o_tdi   = din[i];
            #160;
            o_tck   = 1'b1;
            #160;
            // Output lags the pins by the synchroniser, so read it late
            dout[i] = i_tdo;
            o_tck   = 1'b0;
        end
        o_shift_dr = 1'b0;
        // Released data line no longer shows the last bit
        o_tdi = ~o_tdi;
        if (upd) begin
            o_update_dr = 1'b1;
            tck_pulse();
            o_update_dr = 1'b0;
        end
        // Let the synchronised logic act on the last edge before checks
        #320;
    endtask : dr_scan
    // Two clocks in idle still mean one visit
    task automatic idle_visit();
        o_run_idle = 1'b1;
        tck_pulse();
        tck_pulse();
        o_run_idle = 1'b0;
        tck_pulse();
    endtask : idle_visit
endmodule : jpd_host_model
`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the programming data registers
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        i_clk = 1'b0;
    logic        i_arst_n = 1'b0;
    logic        i_ce = 1'b1;
    logic        i_tck, i_tdi, o_tdo, o_tdo_oe;
    logic [3:0]  i_ir;
    logic        i_shift_dr, i_capture_dr, i_update_dr, i_run_idle;
    logic        o_dev_reset, o_prog_mode, o_cmd_apply, o_cmd_exec;
    logic [14:0] o_cmd;
    logic [14:0] i_cmd_result = 15'h0000;
    logic        o_pb_wr, o_pr_req;
    logic [6:0]  o_pb_addr, o_pr_addr;
    logic [7:0]  o_pb_wdata;
    logic [7:0]  i_pr_rdata = 8'h00;
    int          err_count = 0;
    int          compares = 0;
    int          cycles = 0;
    int          n_apply = 0, n_exec = 0, n_oe = 0;
    logic [14:0] pb_q[$];
    logic [31:0] d;

    always #20 i_clk = ~i_clk;

    jpd_prog_regs u_jpd_prog_regs (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
        .i_tck(i_tck), .i_tdi(i_tdi), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_ir(i_ir),
        .i_shift_dr(i_shift_dr), .i_capture_dr(i_capture_dr), .i_update_dr(i_update_dr),
        .i_run_idle(i_run_idle), .o_dev_reset(o_dev_reset), .o_prog_mode(o_prog_mode),
        .o_cmd(o_cmd), .o_cmd_apply(o_cmd_apply), .o_cmd_exec(o_cmd_exec),
        .i_cmd_result(i_cmd_result), .o_pb_wr(o_pb_wr), .o_pb_addr(o_pb_addr),
        .o_pb_wdata(o_pb_wdata), .o_pr_req(o_pr_req), .o_pr_addr(o_pr_addr),
        .i_pr_rdata(i_pr_rdata));

    jpd_host_model u_jpd_host_model (.o_tck(i_tck), .o_tdi(i_tdi), .i_tdo(o_tdo),
        .o_ir(i_ir), .o_shift_dr(i_shift_dr), .o_capture_dr(i_capture_dr),
        .o_update_dr(i_update_dr), .o_run_idle(i_run_idle));

    // ----------------------------------------
    // Page buffer read side and pulse monitor
    // ----------------------------------------
    // Sampled mid-cycle so one-cycle pulses are never raced
    always @(negedge i_clk) begin
        if (o_pr_req === 1'b1) i_pr_rdata = {1'b0, o_pr_addr} ^ 8'h5a;
        if (o_cmd_apply === 1'b1) n_apply++;
        if (o_cmd_exec === 1'b1) n_exec++;
        if (o_tdo_oe === 1'b1) n_oe++;
        if (o_pb_wr === 1'b1) pb_q.push_back({o_pb_addr, o_pb_wdata});
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_chain();
        chk(o_prog_mode, 0, "enable after reset");
        u_jpd_host_model.set_ir(jpd_pkg::INSTR_DEV_RESET);
        u_jpd_host_model.dr_scan(32'h1, 1, 1'b0, d);
        chk(o_dev_reset, 1, "reset held");
        u_jpd_host_model.dr_scan(32'h0, 1, 1'b0, d);
        chk(d[0], 1, "reset chain out");
        chk(o_dev_reset, 0, "reset released");
    endtask : t_reset_chain

    task automatic t_enable();
        u_jpd_host_model.set_ir(jpd_pkg::INSTR_PROG_EN);
        u_jpd_host_model.dr_scan(32'ha371, 16, 1'b1, d);
        chk(o_prog_mode, 0, "wrong signature");
        u_jpd_host_model.dr_scan({16'h0000, jpd_pkg::PE_SIGNATURE}, 16, 1'b1, d);
        chk(d[15:0], 16'ha371, "enable reg out");
        chk(o_prog_mode, 1, "right signature");
    endtask : t_enable

    task automatic t_command();
        int a0;
        int e0;
        @(negedge i_clk);
        i_cmd_result = 15'h2b5c;
        a0 = n_apply;
        e0 = n_exec;
        u_jpd_host_model.set_ir(jpd_pkg::INSTR_PROG_CMD);
        u_jpd_host_model.dr_scan(32'h4d31, 15, 1'b1, d);
        chk(d[14:0], 15'h2b5c, "previous result out");
        chk(o_cmd, 15'h4d31, "command applied");
        chk(n_apply - a0, 1, "apply pulses");
        chk(n_exec - e0, 0, "no execute outside idle");
        u_jpd_host_model.idle_visit();
        chk(n_exec - e0, 1, "execute pulses");
    endtask : t_command

    task automatic t_page_load();
        pb_q.delete();
        u_jpd_host_model.set_ir(jpd_pkg::INSTR_PAGE_LOAD);
        u_jpd_host_model.dr_scan(32'hc396, 16, 1'b1, d);
        chk(pb_q.size(), 2, "page bytes written");
        chk(pb_q[0], {7'h00, 8'h96}, "first page byte");
        chk(pb_q[1], {7'h01, 8'hc3}, "second page byte");
    endtask : t_page_load

    task automatic t_page_read();
        u_jpd_host_model.set_ir(jpd_pkg::INSTR_PAGE_READ);
        u_jpd_host_model.dr_scan(32'hffffffff, 24, 1'b0, d);
        chk(d[15:8], 8'h00 ^ 8'h5a, "first read byte");
        chk(d[23:16], 8'h01 ^ 8'h5a, "second read byte");
    endtask : t_page_read

    task automatic t_unknown();
        int o0;
        o0 = n_oe;
        u_jpd_host_model.set_ir(4'h3);
        u_jpd_host_model.dr_scan(32'h5, 8, 1'b1, d);
        chk(o0 > 0, 1, "serial output driven on known codes");
        chk(n_oe - o0, 0, "no drive on unknown code");
        chk(o_prog_mode, 1, "mode kept");
    endtask : t_unknown

    // Clock enable low must freeze the chains and the pin sampling
    task automatic t_freeze();
        @(negedge i_clk);
        i_ce = 1'b0;
        u_jpd_host_model.set_ir(jpd_pkg::INSTR_DEV_RESET);
        u_jpd_host_model.dr_scan(32'h1, 1, 1'b0, d);
        chk(o_dev_reset, 0, "state frozen while disabled");
        @(negedge i_clk);
        i_ce = 1'b1;
    endtask : t_freeze

    // Whole run is well under 2000 cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        repeat (4) @(negedge i_clk);
        i_arst_n = 1'b1;
        repeat (4) @(negedge i_clk);
        t_reset_chain();
        t_enable();
        t_command();
        t_page_load();
        t_page_read();
        t_unknown();
        t_freeze();
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
